// >>> hw/bdio_pkg.sv
// Package for the bit-direction I/O ports: port indices, reset values,
// pin positions of the shared functions and the carrier structs.
// Assumes a single clock domain and a CPU-side special-function bus.
package bdio_pkg;

   localparam int BDIO_NPORTS = 5;
   localparam int BDIO_W = 8;

   // Port selectors on the special-function bus
   localparam logic [2:0] BDIO_PORT0 = 3'h0;
   localparam logic [2:0] BDIO_PORT1 = 3'h1;
   localparam logic [2:0] BDIO_PORT2 = 3'h2;
   localparam logic [2:0] BDIO_PORT3 = 3'h3;
   localparam logic [2:0] BDIO_PORT4 = 3'h4;

   // Values after reset: all pins input, latches clear
   localparam logic [7:0] BDIO_DIR_RST = 8'h00;
   localparam logic [7:0] BDIO_LAT_RST = 8'h00;

   // Pin positions of shared functions
   localparam int BDIO_P0_S2_DIN = 0;
   localparam int BDIO_P0_S2_DOUT = 1;
   localparam int BDIO_P0_S2_CLK = 2;
   localparam int BDIO_P0_S2_RDY = 3;
   localparam int BDIO_P2_SUB_OUT = 0;
   localparam int BDIO_P2_SUB_IN = 1;
   localparam int BDIO_P2_SDA1 = 2;
   localparam int BDIO_P2_SCL1 = 3;
   localparam int BDIO_P2_SDA2 = 4;
   localparam int BDIO_P2_SCL2 = 5;
   localparam int BDIO_P2_S1_CLK = 6;
   localparam int BDIO_P2_TX_RDY = 7;
   localparam int BDIO_P4_TY = 0;
   localparam int BDIO_P4_IRQ0 = 1;
   localparam int BDIO_P4_IRQ1 = 2;
   localparam int BDIO_P4_IRQ2 = 3;
   localparam int BDIO_P4_IRQ3 = 4;

   // CPU access to the port registers
   typedef struct packed {
      logic wr;
      logic sel_dir;
      logic [2:0] port;
      logic [7:0] wdata;
   } bdio_req_t;

   // One peripheral's claim on one pin
   typedef struct packed {
      logic en;
      logic oe;
      logic dout;
      logic od;
   } bdio_fn_t;

   // Resolved pin drive
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
   } bdio_drv_t;

endpackage : bdio_pkg

// >>> hw/bdio_pin_cell.sv
// One port bit: direction bit, output latch and peripheral override.
// Assumes the pin input is already synchronised by the parent.
`timescale 1ns/1ns
`default_nettype none
module bdio_pin_cell
   import bdio_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // CPU side
   input wire logic dir_we,
   input wire logic lat_we,
   input wire logic wbit,
   input wire logic pin_sync,
   output logic rbit,
   // Peripheral override
   input wire bdio_fn_t fn,
   // Pin
   output logic pad_out,
   output logic pad_oe
);

   logic dir_r;
   logic lat_r;
   logic out_nxt;
   logic oe_nxt;

   always_ff @(posedge clk) begin
      if (rst) begin
         dir_r <= BDIO_DIR_RST[0];
         lat_r <= BDIO_LAT_RST[0];
      end else begin
         if (dir_we) begin
            dir_r <= wbit;
         end
         if (lat_we) begin
            lat_r <= wbit;
         end
      end
   end

   // Open-drain drives low only; a one releases the line
   assign out_nxt = fn.en ? (fn.od ? 1'b0 : fn.dout) : lat_r;
   assign oe_nxt = fn.en ? (fn.od ? (fn.oe & ~fn.dout) : fn.oe) : dir_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         pad_out <= 1'b0;
         pad_oe <= 1'b0;
      end else begin
         pad_out <= out_nxt;
         pad_oe <= oe_nxt;
      end
   end

   assign rbit = dir_r ? lat_r : pin_sync;

endmodule : bdio_pin_cell
`default_nettype wire

// >>> hw/bdio_ports.sv
// Top of the five 8-bit general-purpose ports with shared functions.
// Assumes a CPU bus on clk issuing one-cycle requests, and pins from
// outside the clock domain.
`timescale 1ns/1ns
`default_nettype none
module bdio_ports
   import bdio_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // CPU access
   input wire bdio_req_t req,
   output logic [7:0] rdata,
   // Pins, port n occupies bits [8n+7:8n]
   input wire logic [39:0] pad_in,
   output logic [39:0] pad_out,
   output logic [39:0] pad_oe,
   // Serial 2 claims
   input wire bdio_fn_t serial2_data_out,
   input wire bdio_fn_t serial2_clock_pin,
   input wire bdio_fn_t serial2_ready_pin,
   input wire bdio_fn_t serial2_compare_out,
   // Bus interface claims
   input wire bdio_fn_t i2c_sda1,
   input wire bdio_fn_t i2c_scl1,
   input wire bdio_fn_t i2c_sda2,
   input wire bdio_fn_t i2c_scl2,
   // Serial 1 claims
   input wire bdio_fn_t serial1_txd,
   input wire bdio_fn_t serial1_rxd,
   input wire bdio_fn_t serial1_clock,
   input wire bdio_fn_t serial1_ready_pin,
   // Timer, PWM, sub-clock claims
   input wire bdio_fn_t timer_x_event_pin,
   input wire bdio_fn_t timer_y_event_pin,
   input wire bdio_fn_t pwm_out,
   input wire bdio_fn_t subclock_osc_out,
   input wire bdio_fn_t subclock_osc_in,
   // Synchronised pin levels for peripherals
   output logic serial2_data_in,
   output logic ext_irq2_in,
   output logic ext_irq3_in,
   output logic [39:0] pin_level
);

   ////////////////////////////////////////////////////////////////////////
   // Pin synchronisers

   logic [39:0] sync1_r;
   logic [39:0] sync2_r;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync1_r <= 40'h0;
         sync2_r <= 40'h0;
      end else begin
         sync1_r <= pad_in;
         sync2_r <= sync1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Peripheral claims per pin

   localparam bdio_fn_t FN_NONE = '0;

   // Priority picker: first enabled claim wins
   function automatic bdio_fn_t pick2(input bdio_fn_t a, input bdio_fn_t b);
      pick2 = a.en ? a : (b.en ? b : FN_NONE);
   endfunction : pick2

   bdio_fn_t fn_pin [40];
   bdio_fn_t sda2_sel;
   bdio_fn_t scl2_sel;
   bdio_fn_t p27_sel;
   bdio_fn_t p43_sel;
   bdio_fn_t p44_sel;

   // Bus function forces open-drain; else the serial 1 three-state driver
   assign sda2_sel = i2c_sda2.en ? bdio_fn_t'{1'b1, i2c_sda2.oe, i2c_sda2.dout, 1'b1}
                                 : serial1_rxd;
   assign scl2_sel = i2c_scl2.en ? bdio_fn_t'{1'b1, i2c_scl2.oe, i2c_scl2.dout, 1'b1}
                                 : serial1_txd;
   assign p27_sel = pick2(timer_x_event_pin, serial1_ready_pin);
   assign p43_sel = serial2_compare_out;
   assign p44_sel = pwm_out;

   always_comb begin
      for (int i = 0; i < 40; i++) begin
         fn_pin[i] = FN_NONE;
      end
      fn_pin[8*0 + BDIO_P0_S2_DOUT] = serial2_data_out;
      fn_pin[8*0 + BDIO_P0_S2_CLK] = serial2_clock_pin;
      fn_pin[8*0 + BDIO_P0_S2_RDY] = serial2_ready_pin;
      fn_pin[8*2 + BDIO_P2_SUB_OUT] = subclock_osc_out;
      fn_pin[8*2 + BDIO_P2_SUB_IN] = subclock_osc_in;
      fn_pin[8*2 + BDIO_P2_SDA1] = '{i2c_sda1.en, i2c_sda1.oe, i2c_sda1.dout, 1'b1};
      fn_pin[8*2 + BDIO_P2_SCL1] = '{i2c_scl1.en, i2c_scl1.oe, i2c_scl1.dout, 1'b1};
      fn_pin[8*2 + BDIO_P2_SDA2] = sda2_sel;
      fn_pin[8*2 + BDIO_P2_SCL2] = scl2_sel;
      fn_pin[8*2 + BDIO_P2_S1_CLK] = serial1_clock;
      fn_pin[8*2 + BDIO_P2_TX_RDY] = p27_sel;
      fn_pin[8*4 + BDIO_P4_TY] = timer_y_event_pin;
      fn_pin[8*4 + BDIO_P4_IRQ2] = p43_sel;
      fn_pin[8*4 + BDIO_P4_IRQ3] = p44_sel;
   end

   ////////////////////////////////////////////////////////////////////////
   // Per-bit cells

   logic [39:0] rbits;
   logic [4:0] port_hit;

   genvar g;
   generate
      for (g = 0; g < 40; g++) begin : g_bit
         bdio_pin_cell u_cell (
            .clk(clk),
            .rst(rst),
            .dir_we(req.wr & req.sel_dir & port_hit[g/8]),
            .lat_we(req.wr & ~req.sel_dir & port_hit[g/8]),
            .wbit(req.wdata[g%8]),
            .pin_sync(sync2_r[g]),
            .rbit(rbits[g]),
            .fn(fn_pin[g]),
            .pad_out(pad_out[g]),
            .pad_oe(pad_oe[g])
         );
      end
      for (g = 0; g < 5; g++) begin : g_hit
         assign port_hit[g] = (req.port == 3'(g));
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // Read path, registered

   logic [7:0] dir_shadow [5];
   logic [7:0] rd_nxt;

   // Direction bits are shadowed here so a read of the direction
   // register returns what was written
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < 5; i++) begin
            dir_shadow[i] <= BDIO_DIR_RST;
         end
      end else if (req.wr & req.sel_dir & (req.port < 3'h5)) begin
         dir_shadow[req.port] <= req.wdata;
      end
   end

   assign rd_nxt = (req.port > BDIO_PORT4) ? 8'h00 :
                   req.sel_dir ? dir_shadow[req.port] :
                   rbits[8*req.port +: 8];

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
         serial2_data_in <= 1'b0;
         ext_irq2_in <= 1'b0;
         ext_irq3_in <= 1'b0;
         pin_level <= 40'h0;
      end else begin
         rdata <= rd_nxt;
         serial2_data_in <= sync2_r[8*0 + BDIO_P0_S2_DIN];
         ext_irq2_in <= sync2_r[8*4 + BDIO_P4_IRQ2];
         ext_irq3_in <= sync2_r[8*4 + BDIO_P4_IRQ3];
         pin_level <= sync2_r;
      end
   end

endmodule : bdio_ports
`default_nettype wire

// >>> tb/bdio_board_model.sv
// Board model for the port pins.
// Assumes the bench supplies the outside level of every undriven pin.
`timescale 1ns/1ns
`default_nettype none
module bdio_board_model (
   // Pins
   input wire logic [39:0] pad_out,
   input wire logic [39:0] pad_oe,
   input wire logic [39:0] ext_lvl,
   output logic [39:0] pad_in
);
   // A driven pin shows its own drive; a floating one only the outside level
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_lvl);
endmodule : bdio_board_model
`default_nettype wire

// >>> tb/bdio_ports_assertions.sv
// Checker on the port top: direction, latch, readback and claims.
// Assumes it is bound into bdio_ports and sees only its ports.
`timescale 1ns/1ns
`default_nettype none
module bdio_ports_chk
   import bdio_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Watched ports
   input wire bdio_req_t req,
   input wire logic [7:0] rdata,
   input wire logic [39:0] pad_out,
   input wire logic [39:0] pad_oe,
   input wire bdio_fn_t serial2_data_out,
   input wire bdio_fn_t i2c_sda1,
   input wire bdio_fn_t pwm_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   // Port 1 has no shared function, so its pads show the registers alone
   wire logic dwr1 = req.wr && req.sel_dir && (req.port == 3'h1);
   wire logic lwr1 = req.wr && !req.sel_dir && (req.port == 3'h1);
   wire logic rd1 = !req.wr && (req.port == 3'h1);
   wire logic bad = req.port > 3'h4;
   ////////////////////////////////////////////////////////////////////////////
   a_reset_clear: assert property ($fell(rst) |-> pad_oe == 40'h0 && rdata == 8'h00)
      else $error("pads or read data not clear after reset");
   a_dir_to_oe: assert property (dwr1 |-> ##2 pad_oe[15:8] == $past(req.wdata, 2))
      else $error("direction write did not reach the pad enables");
   a_latch_to_pad: assert property (lwr1 |-> ##2
      (pad_out[15:8] & pad_oe[15:8]) == ($past(req.wdata, 2) & pad_oe[15:8]))
      else $error("latch write did not reach the driven pads");
   a_oe_needs_dir: assert property (pad_oe[15:8] != $past(pad_oe[15:8]) |->
      $past(dwr1, 2) || $past(rst))
      else $error("pad enable changed without a direction write");
   a_read_dir: assert property (rd1 && req.sel_dir |=> rdata == pad_oe[15:8])
      else $error("direction readback wrong");
   a_read_latch: assert property (rd1 && !req.sel_dir |=>
      (rdata & pad_oe[15:8]) == (pad_out[15:8] & pad_oe[15:8]))
      else $error("output pin did not read its latch");
   a_bad_read: assert property (!req.wr && bad |=> rdata == 8'h00)
      else $error("unmapped port read not zero");
   a_bad_write: assert property (req.wr && bad |-> ##2 $stable(pad_oe[15:8]))
      else $error("unmapped port write changed a port");
   a_claim_s2: assert property (serial2_data_out.en && !serial2_data_out.od |=>
      pad_oe[1] == $past(serial2_data_out.oe) &&
      (!pad_oe[1] || pad_out[1] == $past(serial2_data_out.dout)))
      else $error("serial 2 output claim not on its pin");
   a_claim_pwm: assert property (pwm_out.en && !pwm_out.od |=>
      pad_oe[36] == $past(pwm_out.oe) && (!pad_oe[36] || pad_out[36] == $past(pwm_out.dout)))
      else $error("pwm claim not on its pin");
   a_sda_open: assert property (i2c_sda1.en [*2] |-> !(pad_oe[18] && pad_out[18]))
      else $error("bus data pin driven high");
endmodule : bdio_ports_chk
bind bdio_ports bdio_ports_chk i_bdio_ports_chk (.clk(clk), .rst(rst), .req(req), .rdata(rdata),
   .pad_out(pad_out), .pad_oe(pad_oe), .serial2_data_out(serial2_data_out),
   .i2c_sda1(i2c_sda1), .pwm_out(pwm_out));
`default_nettype wire

// >>> tb/test_bit_direction_io_ports.sv
// Self-checking bench for the five general-purpose ports.
// Assumes the board model closes the pin loop and all claims start idle.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, (a), (e)); end end
module test_bit_direction_io_ports;
   import bdio_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   bdio_req_t req = '0;
   logic [7:0] rdata;
   logic [39:0] pad_in, pad_out, pad_oe, pin_level;
   logic [39:0] ext_lvl = 40'h0;
   logic s2_din, irq2, irq3;
   bdio_fn_t fn [17];
   int n_errors = 0;
   int n_checks = 0;
   always #2 clk = ~clk;
   bdio_board_model i_bdio_board_model (.pad_out(pad_out), .pad_oe(pad_oe), .ext_lvl(ext_lvl),
      .pad_in(pad_in));
   bdio_ports i_bdio_ports (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .serial2_data_out(fn[0]), .serial2_clock_pin(fn[1]),
      .serial2_ready_pin(fn[2]), .serial2_compare_out(fn[3]), .i2c_sda1(fn[4]), .i2c_scl1(fn[5]),
      .i2c_sda2(fn[6]), .i2c_scl2(fn[7]), .serial1_txd(fn[8]), .serial1_rxd(fn[9]),
      .serial1_clock(fn[10]), .serial1_ready_pin(fn[11]), .timer_x_event_pin(fn[12]),
      .timer_y_event_pin(fn[13]), .pwm_out(fn[14]), .subclock_osc_out(fn[15]),
      .subclock_osc_in(fn[16]), .serial2_data_in(s2_din), .ext_irq2_in(irq2),
      .ext_irq3_in(irq3), .pin_level(pin_level));
   ////////////////////////////////////////////////////////////////////////////
   task automatic access(input logic w, input logic s, input logic [2:0] p, input logic [7:0] d);
      @(negedge clk);
      req = '{w, s, p, d};
      @(negedge clk);
      req.wr = 1'b0;
   endtask : access
   task automatic rd(input logic s, input logic [2:0] p, output logic [7:0] v);
      access(1'b0, s, p, 8'h00);
      v = rdata;
   endtask : rd
   // Covers the pad flop and the two-flop pin synchroniser
   task automatic settle;
      repeat (4) @(negedge clk);
   endtask : settle
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_dirs;
      logic [7:0] v;
      rd(1'b1, 3'h2, v);
      `CHK(v, BDIO_DIR_RST)
      `CHK(pad_oe, 40'h0)
      for (int p = 0; p < 5; p++) access(1'b1, 1'b1, p[2:0], 8'h5a ^ p[7:0]);
      settle();
      for (int p = 0; p < 5; p++) `CHK(pad_oe[8*p +: 8], 8'h5a ^ p[7:0])
   endtask : t_dirs
   task automatic t_readback;
      logic [7:0] v;
      access(1'b1, 1'b0, 3'h1, 8'h0f);
      ext_lvl[15:8] = 8'ha5;
      settle();
      `CHK(pad_oe[15:8], 8'h5b)
      `CHK(pad_out[15:8] & 8'h5b, 8'h0b)
      rd(1'b0, 3'h1, v);
      `CHK(v, 8'haf)
      rd(1'b1, 3'h1, v);
      `CHK(v, 8'h5b)
      access(1'b1, 1'b1, 3'h5, 8'hff);
      access(1'b1, 1'b0, 3'h7, 8'h00);
      settle();
      `CHK(pad_oe[15:8], 8'h5b)
      rd(1'b1, 3'h6, v);
      `CHK(v, 8'h00)
   endtask : t_readback
   task automatic t_claims;
      int pins [10] = '{1, 2, 3, 35, 21, 22, 23, 23, 32, 36};
      int idx [10] = '{0, 1, 2, 3, 8, 10, 11, 12, 13, 14};
      for (int i = 0; i < 10; i++) begin
         for (int b = 0; b < 2; b++) begin
            @(negedge clk);
            fn[idx[i]] = '{1'b1, 1'b1, b[0], 1'b0};
            settle();
            `CHK(pad_oe[pins[i]], 1'b1)
            `CHK(pad_out[pins[i]], b[0])
         end
         fn[idx[i]] = '0;
      end
      fn[4] = '{1'b1, 1'b1, 1'b1, 1'b0};
      settle();
      `CHK(pad_oe[18], 1'b0)
      fn[4].dout = 1'b0;
      settle();
      `CHK({pad_oe[18], pad_out[18]}, 2'b10)
      fn[4] = '0;
      ext_lvl[0] = 1'b1;
      settle();
      `CHK(s2_din, 1'b1)
   endtask : t_claims
   // Interrupt inputs, bus-over-serial priority, then a reset in mid-run
   task automatic t_shared;
      logic [7:0] v;
      access(1'b1, 1'b1, 3'h4, 8'h00);
      ext_lvl[39:32] = 8'h18;
      fn[6] = '{1'b1, 1'b1, 1'b1, 1'b0};
      fn[9] = '{1'b1, 1'b1, 1'b1, 1'b0};
      fn[5] = '{1'b1, 1'b1, 1'b0, 1'b0};
      fn[15] = '{1'b1, 1'b1, 1'b1, 1'b0};
      settle();
      `CHK({irq3, irq2}, 2'b11)
      `CHK(pin_level[39:32], 8'h18)
      `CHK({pad_oe[20], pad_out[20]}, 2'b00)
      `CHK({pad_oe[19], pad_out[19]}, 2'b10)
      `CHK({pad_oe[16], pad_out[16]}, 2'b11)
      rd(1'b0, 3'h4, v);
      `CHK(v, 8'h18)
      fn[6] = '0;
      settle();
      `CHK({pad_oe[20], pad_out[20]}, 2'b11)
      fn[9] = '0;
      fn[5] = '0;
      fn[15] = '0;
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK(pad_oe, 40'h0)
      rd(1'b1, 3'h1, v);
      `CHK(v, BDIO_DIR_RST)
   endtask : t_shared
   ////////////////////////////////////////////////////////////////////////////
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : stop_test
   initial begin
      foreach (fn[i]) fn[i] = '0;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      t_dirs();
      t_readback();
      t_claims();
      t_shared();
      stop_test();
   end
   // The run needs well under a thousand cycles
   initial begin
      #20000;
      n_errors++;
      stop_test();
   end
endmodule : test_bit_direction_io_ports
`default_nettype wire
